// ---- design/bdc_defs.svh ----
// constants for the beer cabinet front-panel control
// assumes a single 20 MHz clock and second-scale timers from a tick
//
// What this block does
// - sleeping panel wakes on press, confirm tone
// - power-up shows power-failure alarm, power press clears
// - 60 s idle sleeps panel, OK stays lit
// - any active alarm wakes the display
// - on/off, set-point, vacation need awake display
// - 4 s power hold toggles on/off
// - minus/plus while awake enters set-point mode
// - further minus/plus steps set-point down/up
// - power press or 10 s idle accepts
// - set-point held 34..46 F, limit tone
// - Fahrenheit default, minus-plus-release toggles unit
// - lock hold locks, icon flashes thrice
// - repeated lock hold unlocks panel
// - door open 5 min raises door alarm
// - door close or power press clears, recurs
// - power failure alarm flashes, no tone
// - 10 F deviation for 1 h raises alarm
// - alarms tracked independently, may coexist
// - long power hold enters vacation, flashes thrice
// - vacation disables panel, keys except power
// - door changes nothing in vacation
// - vacation survives outage, long hold exits
// - longer lock hold toggles display sleep
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH
`define BDC_CLK_HZ 20000000
`define BDC_MS_PER_S 1000
`define BDC_TICK_MS 100
`define BDC_DB_MS 20
`define BDC_SLEEP_S 60
`define BDC_HOLD_ONOFF_S 4
`define BDC_HOLD_VAC_S 8
`define BDC_HOLD_LOCK_S 3
`define BDC_HOLD_NSL_S 6
`define BDC_SET_TO_S 10
`define BDC_DOOR_MIN 5
`define BDC_S_PER_MIN 60
`define BDC_TEMP_HR 1
`define BDC_S_PER_HR 3600
`define BDC_TONE_S 60
`define BDC_FLASH_MS 500
`define BDC_FLASH_N 3
`define BDC_SP_MIN_F 34
`define BDC_SP_MAX_F 46
`define BDC_SP_DEF_F 38
`define BDC_TEMP_DEV_F 10
`define BDC_F_ZERO_C 32
`define BDC_CF_NUM 5
`define BDC_CF_DEN 9
`define BDC_TENTHS 10
`define BDC_K_PWR 3
`define BDC_K_MINUS 2
`define BDC_K_PLUS 1
`define BDC_K_LOCK 0
`endif

// ---- design/bdc_pkg.sv ----
// types shared by the panel control
// assumes nothing beyond the constants header
package bdc_pkg;
   typedef struct packed {
      logic power;
      logic minus;
      logic plus;
      logic lock;
   } bdc_keys_t;
   typedef struct packed {
      logic ok;
      logic doorAjar;
      logic powerFail;
      logic tempAlarm;
      logic alarmReset;
      logic setInd;
      logic lockIcon;
      logic celsius;
   } bdc_leds_t;
   typedef struct packed {
      logic confirm;
      logic limit;
      logic alarm;
   } bdc_tones_t;
   typedef enum logic [3:0] {
      MSG_TEMP, MSG_SETPT, MSG_OFF, MSG_LOCK, MSG_UNLOCK,
      MSG_VAC, MSG_NOSLEEP, MSG_SLEEPEN
   } bdc_msg_t;
endpackage

// ---- design/bdc_debounce.sv ----
// key debouncer: level follows raw once raw is stable
// assumes raw is synchronous to mclk, active high
`timescale 1ns/1ps
`include "bdc_defs.svh"
module bdc_debounce #(
   parameter int CYCLES = `BDC_CLK_HZ / `BDC_MS_PER_S * `BDC_DB_MS
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // key
   input wire logic raw,
   output logic level_r
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_r;
   wire stable = (raw == level_r);
   wire done = (cnt_r == CW'(CYCLES - 1));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         level_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= (stable || done) ? '0 : cnt_r + 1'b1;
         if (!stable && done) begin
            level_r <= raw;
         end
      end
   end
endmodule

// ---- design/bdc_panel.sv ----
// front-panel control: keys, display, sleep, set-point, lock, alarms
// assumes keys, door and temperature synchronous to mclk
`timescale 1ns/1ps
`include "bdc_defs.svh"
module bdc_panel #(
   parameter int TICK_CYCLES = `BDC_CLK_HZ / `BDC_MS_PER_S * `BDC_TICK_MS,
   parameter int DB_CYCLES = `BDC_CLK_HZ / `BDC_MS_PER_S * `BDC_DB_MS,
   parameter int TEMP_TICKS =
      `BDC_TEMP_HR * `BDC_S_PER_HR * `BDC_MS_PER_S / `BDC_TICK_MS
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // keypad and sensors
   input wire bdc_pkg::bdc_keys_t keyRaw,
   input wire logic doorOpen,
   input wire logic signed [7:0] cabTempF,
   input wire logic vacKeep,
   // panel
   output bdc_pkg::bdc_leds_t leds_r,
   output bdc_pkg::bdc_tones_t tones_r,
   output bdc_pkg::bdc_msg_t dispMsg_r,
   output logic dispOn_r,
   output logic signed [15:0] dispTenths_r,
   // appliance state
   output logic applianceOn_r,
   output logic vacation_r,
   output logic [7:0] setPointF_r
);
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int TPS = `BDC_MS_PER_S / `BDC_TICK_MS;
   localparam int TW = $clog2(TICK_CYCLES);
   localparam logic [15:0] SLEEP_T = 16'(`BDC_SLEEP_S * TPS);
   localparam logic [15:0] HOLD_T = 16'(`BDC_HOLD_ONOFF_S * TPS);
   localparam logic [15:0] VAC_T = 16'(`BDC_HOLD_VAC_S * TPS);
   localparam logic [15:0] LOCK_T = 16'(`BDC_HOLD_LOCK_S * TPS);
   localparam logic [15:0] NSL_T = 16'(`BDC_HOLD_NSL_S * TPS);
   localparam logic [15:0] SET_T = 16'(`BDC_SET_TO_S * TPS);
   localparam logic [15:0] DOOR_T = 16'(`BDC_DOOR_MIN * `BDC_S_PER_MIN * TPS);
   localparam logic [15:0] TONE_T = 16'(`BDC_TONE_S * TPS);
   localparam logic [15:0] TEMP_T = 16'(TEMP_TICKS);
   localparam logic [3:0] FLASH_T = 4'(`BDC_FLASH_MS / `BDC_TICK_MS);
   localparam logic [2:0] FLASH_N = 3'(2 * `BDC_FLASH_N);
   localparam logic [7:0] SP_MIN = 8'(`BDC_SP_MIN_F);
   localparam logic [7:0] SP_MAX = 8'(`BDC_SP_MAX_F);
   localparam logic signed [8:0] DEV = 9'(`BDC_TEMP_DEV_F);
   localparam logic signed [15:0] F_OFS = 16'(`BDC_F_ZERO_C);
   localparam logic signed [15:0] CF_MUL = 16'(`BDC_CF_NUM * `BDC_TENTHS);
   localparam logic signed [15:0] CF_DEN = 16'(`BDC_CF_DEN);
   localparam logic signed [15:0] TEN = 16'(`BDC_TENTHS);

   function automatic logic signed [15:0] toTenths(input logic signed [7:0] f,
                                                   input logic cel);
      logic signed [15:0] fx;
      fx = 16'(f);
      toTenths = cel ? 16'(((fx - F_OFS) * CF_MUL) / CF_DEN) : 16'(fx * TEN);
   endfunction

   logic [TW-1:0] tickCnt_r;
   wire tick = (tickCnt_r == TW'(TICK_CYCLES - 1));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) tickCnt_r <= '0;
      else if (ce) tickCnt_r <= tick ? '0 : tickCnt_r + 1'b1;
   end

   // ----------------------------------------
   // keys
   // ----------------------------------------
   logic [3:0] keyDb;
   logic [3:0] keyPrev_r;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_db
         bdc_debounce #(.CYCLES(DB_CYCLES)) u_db (
            .mclk(mclk),
            .rst_b(rst_b),
            .ce(ce),
            .raw(keyRaw[gi]),
            .level_r(keyDb[gi])
         );
      end
   endgenerate

   wire [3:0] rise = keyDb & ~keyPrev_r;
   wire [3:0] fall = ~keyDb & keyPrev_r;
   wire anyRise = |rise;
   wire pwrRise = rise[`BDC_K_PWR];
   wire pwrFall = fall[`BDC_K_PWR];
   wire minusRise = rise[`BDC_K_MINUS];
   wire minusFall = fall[`BDC_K_MINUS];
   wire minusHeld = keyDb[`BDC_K_MINUS];
   wire plusRise = rise[`BDC_K_PLUS];
   wire lockFall = fall[`BDC_K_LOCK];

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic started_r, awake_r, noSleep_r, locked_r, setMode_r, celsius_r;
   logic comboArm_r, wakeAtPwr_r, doorAlarm_r, tempAlarm_r, pwrFail_r;
   logic flashPh_r;
   logic [15:0] idleCnt_r, setIdle_r, pwrHold_r, lockHold_r;
   logic [15:0] doorCnt_r, tempCnt_r, toneCnt_r;
   logic [7:0] editF_r;
   logic [3:0] flashCnt_r;
   logic [2:0] lockFlash_r, vacFlash_r;

   wire vacation_message = vacation_r;
   wire funcOk = awake_r && !vacation_message && !locked_r && applianceOn_r;
   wire pwrOk = wakeAtPwr_r && !locked_r && !vacation_message;
   wire pwrShort = pwrFall && (pwrHold_r < HOLD_T);
   wire pwrLong = pwrFall && (pwrHold_r >= HOLD_T) && (pwrHold_r < VAC_T);
   wire pwrVac = pwrFall && (pwrHold_r >= VAC_T);
   wire alarmClr = pwrShort && !locked_r && !vacation_message && !setMode_r;
   wire toggleOn = pwrLong && pwrOk && !setMode_r;
   wire enterVac = pwrVac && pwrOk && !setMode_r;
   wire exitVac = vacation_message && pwrFall && (pwrHold_r >= HOLD_T);
   wire lockHoldOk = lockFall && !vacation_message && (lockHold_r >= LOCK_T);
   wire lockTog = lockHoldOk && (lockHold_r < NSL_T);
   wire nslTog = lockHoldOk && (lockHold_r >= NSL_T);
   wire setEnter = !setMode_r && funcOk && (minusRise || (plusRise && !minusHeld));
   wire stepDn = setMode_r && funcOk && minusRise;
   wire stepUp = setMode_r && funcOk && plusRise && !minusHeld;
   wire atMin = (editF_r <= SP_MIN);
   wire atMax = (editF_r >= SP_MAX);
   wire limitHit = (stepDn && atMin) || (stepUp && atMax);
   wire comboSet = plusRise && minusHeld && awake_r && !vacation_message && !locked_r;
   wire comboFire = minusFall && comboArm_r;
   wire setTimeout = setMode_r && tick && (setIdle_r == SET_T - 16'h0001);
   wire accept = setMode_r && ((pwrRise && funcOk) || setTimeout);
   wire setAny = setEnter || stepDn || stepUp;

   wire signed [8:0] tempDiff = {cabTempF[7], cabTempF} - $signed({1'b0, setPointF_r});
   wire tempDev = (tempDiff > DEV) || (tempDiff < -DEV);
   wire doorSet = tick && doorOpen && !vacation_message && !doorAlarm_r
                  && (doorCnt_r == DOOR_T - 16'h0001);
   wire doorClr = !doorOpen || alarmClr;
   wire tempSet = tick && tempDev && !vacation_message && !tempAlarm_r
                  && (tempCnt_r == TEMP_T - 16'h0001);
   wire sndAlarm = doorAlarm_r || tempAlarm_r;
   wire anyAlarm = sndAlarm || pwrFail_r;
   wire alarmsOn = anyAlarm && !vacation_message;
   wire toneRep = tick && sndAlarm && (toneCnt_r == TONE_T - 16'h0001);
   wire toneAlarmEv = !vacation_message && (doorSet || tempSet || toneRep);
   wire sleepNow = awake_r && tick && !noSleep_r && !alarmsOn
                   && (idleCnt_r == SLEEP_T - 16'h0001) && !anyRise;
   wire flashStep = tick && (flashCnt_r == FLASH_T - 4'h1);

   // restores vacation after an outage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         started_r <= 1'b0;
         vacation_r <= 1'b0;
      end else if (ce) begin
         started_r <= 1'b1;
         if (!started_r) vacation_r <= vacKeep;
         else if (enterVac) vacation_r <= 1'b1;
         else if (exitVac) vacation_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         keyPrev_r <= '0;
         pwrHold_r <= '0;
         lockHold_r <= '0;
         wakeAtPwr_r <= 1'b0;
      end else if (ce) begin
         keyPrev_r <= keyDb;
         if (pwrRise) wakeAtPwr_r <= awake_r;
         if (pwrRise) pwrHold_r <= '0;
         else if (keyDb[`BDC_K_PWR] && tick && pwrHold_r != '1)
            pwrHold_r <= pwrHold_r + 16'h0001;
         if (rise[`BDC_K_LOCK]) lockHold_r <= '0;
         else if (keyDb[`BDC_K_LOCK] && tick && lockHold_r != '1)
            lockHold_r <= lockHold_r + 16'h0001;
      end
   end

   // ----------------------------------------
   // sleep, on/off, lock
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awake_r <= 1'b1;
         idleCnt_r <= '0;
      end else if (ce) begin
         if (anyRise || alarmsOn) awake_r <= 1'b1;
         else if (sleepNow) awake_r <= 1'b0;
         if (anyRise || !awake_r) idleCnt_r <= '0;
         else if (tick) idleCnt_r <= idleCnt_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         applianceOn_r <= 1'b1;
         noSleep_r <= 1'b0;
         locked_r <= 1'b0;
         lockFlash_r <= '0;
      end else if (ce) begin
         if (toggleOn) applianceOn_r <= !applianceOn_r;
         if (nslTog) noSleep_r <= !noSleep_r;
         if (lockTog) locked_r <= !locked_r;
         if (lockTog && !locked_r) lockFlash_r <= FLASH_N;
         else if (flashStep && lockFlash_r != '0) lockFlash_r <= lockFlash_r - 3'h1;
      end
   end

   // ----------------------------------------
   // set-point and unit
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         setMode_r <= 1'b0;
         editF_r <= 8'(`BDC_SP_DEF_F);
         setPointF_r <= 8'(`BDC_SP_DEF_F);
         setIdle_r <= '0;
      end else if (ce) begin
         if (accept) setPointF_r <= editF_r;
         if (setEnter) setMode_r <= 1'b1;
         else if (accept || !awake_r || vacation_message || locked_r) setMode_r <= 1'b0;
         if (setEnter) editF_r <= setPointF_r;
         else if (stepDn && !atMin) editF_r <= editF_r - 8'h01;
         else if (stepUp && !atMax) editF_r <= editF_r + 8'h01;
         if (setAny) setIdle_r <= '0;
         else if (tick) setIdle_r <= setIdle_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         celsius_r <= 1'b0;
         comboArm_r <= 1'b0;
      end else if (ce) begin
         if (comboSet) comboArm_r <= 1'b1;
         else if (minusFall) comboArm_r <= 1'b0;
         if (comboFire) celsius_r <= !celsius_r;
      end
   end

   // ----------------------------------------
   // alarms
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         doorAlarm_r <= 1'b0;
         doorCnt_r <= '0;
      end else if (ce) begin
         if (doorSet) doorAlarm_r <= 1'b1;
         else if (doorClr) doorAlarm_r <= 1'b0;
         if (!doorOpen || vacation_message || doorAlarm_r || doorSet) doorCnt_r <= '0;
         else if (tick) doorCnt_r <= doorCnt_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tempAlarm_r <= 1'b0;
         tempCnt_r <= '0;
         pwrFail_r <= 1'b1;
         toneCnt_r <= '0;
      end else if (ce) begin
         if (tempSet) tempAlarm_r <= 1'b1;
         else if (alarmClr) tempAlarm_r <= 1'b0;
         if (!tempDev || vacation_message || tempAlarm_r || tempSet) tempCnt_r <= '0;
         else if (tick) tempCnt_r <= tempCnt_r + 16'h0001;
         if (alarmClr) pwrFail_r <= 1'b0;
         if (!sndAlarm || toneRep) toneCnt_r <= '0;
         else if (tick) toneCnt_r <= toneCnt_r + 16'h0001;
      end
   end

   // ----------------------------------------
   // flashing and outputs
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flashCnt_r <= '0;
         flashPh_r <= 1'b1;
         vacFlash_r <= '0;
      end else if (ce) begin
         if (flashStep) flashCnt_r <= '0;
         else if (tick) flashCnt_r <= flashCnt_r + 4'h1;
         if (flashStep) flashPh_r <= !flashPh_r;
         if (enterVac) vacFlash_r <= FLASH_N;
         else if (flashStep && vacFlash_r != '0) vacFlash_r <= vacFlash_r - 3'h1;
      end
   end

   bdc_pkg::bdc_leds_t ledsNxt;
   bdc_pkg::bdc_msg_t msgNxt;
   wire live = !vacation_message && awake_r;
   wire flashDisp = vacation_message ? (vacFlash_r != '0) : setMode_r;
   wire dispOnNxt = (vacation_message || awake_r) && !(flashDisp && !flashPh_r);
   wire signed [15:0] tenthsNxt = toTenths(setMode_r ? editF_r : cabTempF,
                                           celsius_r);

   always_comb begin
      ledsNxt.ok = !vacation_message && !anyAlarm;
      ledsNxt.doorAjar = !vacation_message && doorAlarm_r && flashPh_r;
      ledsNxt.powerFail = !vacation_message && pwrFail_r && flashPh_r;
      ledsNxt.tempAlarm = !vacation_message && tempAlarm_r && flashPh_r;
      ledsNxt.alarmReset = alarmsOn;
      ledsNxt.setInd = live && setMode_r;
      ledsNxt.lockIcon = live && locked_r && (lockFlash_r == '0 || flashPh_r);
      ledsNxt.celsius = live && celsius_r;
      if (vacation_message && keyDb[`BDC_K_PWR] && pwrHold_r >= HOLD_T) msgNxt = bdc_pkg::MSG_TEMP;
      else if (vacation_message) msgNxt = bdc_pkg::MSG_VAC;
      else if (keyDb[`BDC_K_PWR] && wakeAtPwr_r && pwrHold_r >= VAC_T)
         msgNxt = bdc_pkg::MSG_VAC;
      else if (keyDb[`BDC_K_PWR] && wakeAtPwr_r && pwrHold_r >= HOLD_T)
         msgNxt = applianceOn_r ? bdc_pkg::MSG_OFF : bdc_pkg::MSG_TEMP;
      else if (keyDb[`BDC_K_LOCK] && lockHold_r >= NSL_T)
         msgNxt = noSleep_r ? bdc_pkg::MSG_SLEEPEN : bdc_pkg::MSG_NOSLEEP;
      else if (keyDb[`BDC_K_LOCK] && lockHold_r >= LOCK_T)
         msgNxt = locked_r ? bdc_pkg::MSG_UNLOCK : bdc_pkg::MSG_LOCK;
      else if (setMode_r) msgNxt = bdc_pkg::MSG_SETPT;
      else if (!applianceOn_r) msgNxt = bdc_pkg::MSG_OFF;
      else msgNxt = bdc_pkg::MSG_TEMP;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         leds_r <= '0;
         tones_r <= '0;
         dispMsg_r <= bdc_pkg::MSG_TEMP;
         dispOn_r <= 1'b0;
         dispTenths_r <= '0;
      end else if (ce) begin
         leds_r <= ledsNxt;
         tones_r.confirm <= anyRise && !awake_r && !vacation_message;
         tones_r.limit <= limitHit;
         tones_r.alarm <= toneAlarmEv;
         dispMsg_r <= msgNxt;
         dispOn_r <= dispOnNxt;
         dispTenths_r <= tenthsNxt;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   wake_press_a: assert property (ce && anyRise && !awake_r && !vacation_message |=> awake_r && tones_r.confirm) else $error("press did not wake");
   pwr_clear_a: assert property (ce && alarmClr |=> !pwrFail_r && (!tempAlarm_r || $past(tempSet))) else $error("alarm not cleared");
   sleep_go_a: assert property (ce && sleepNow |=> !awake_r ##1 (!ce || leds_r.ok || alarmsOn)) else $error("sleep entry wrong");
   alarm_wake_a: assert property (ce && alarmsOn |=> awake_r) else $error("alarm left display asleep");
   asleep_ignore_a: assert property (ce && pwrFall && !wakeAtPwr_r |=> $stable(applianceOn_r) && !vacation_r || $past(vacation_message)) else $error("asleep key acted");
   hold_toggle_a: assert property (ce && toggleOn |=> applianceOn_r != $past(applianceOn_r)) else $error("on/off not toggled");
   sp_range_a: assert property (editF_r >= SP_MIN && editF_r <= SP_MAX && setPointF_r >= SP_MIN && setPointF_r <= SP_MAX) else $error("set-point out of range");
   limit_tone_a: assert property (ce && limitHit |=> tones_r.limit && $stable(editF_r)) else $error("limit not signalled");
   unit_flip_a: assert property (ce && comboFire |=> celsius_r != $past(celsius_r)) else $error("unit not toggled");
   door_clear_a: assert property (ce && !doorOpen |=> !doorAlarm_r) else $error("door alarm stuck");
   vac_quiet_a: assert property (ce && vacation_message |=> leds_r == '0 && tones_r == '0) else $error("vacation not quiet");
   vac_lock_a: assert property (ce && vacation_message && lockFall |=> $stable(locked_r) && $stable(noSleep_r)) else $error("lock acted in vacation");

   set_enter_c: cover property (ce && setEnter ##[1:300] accept);
   vac_enter_c: cover property (ce && enterVac);
   door_alarm_c: cover property (ce && doorSet);
   both_alarm_c: cover property (doorAlarm_r && tempAlarm_r);
endmodule

// ---- verif/bdc_front_model.sv ----
// keypad, door and cabinet sensor stand-in for the panel control
// assumes the bench commands keys, door and temperature at falling edges
`timescale 1ns/1ps
module bdc_front_model (
   // bench commands
   input wire bdc_pkg::bdc_keys_t cmdKeys,
   input wire logic cmdDoor,
   input wire logic signed [7:0] cmdTemp,
   // panel side
   input wire logic rst_b,
   input wire logic vacation_r,
   output bdc_pkg::bdc_keys_t keyRaw,
   output logic doorOpen,
   output logic signed [7:0] cabTempF,
   output logic vacKeep
);
   logic vacStore = 1'b0;
   assign keyRaw = cmdKeys;
   assign doorOpen = cmdDoor;
   assign cabTempF = cmdTemp;
   // nonvolatile store, written only while out of reset
   always @(vacation_r) if (rst_b === 1'b1) vacStore = vacation_r;
   assign vacKeep = vacStore;
endmodule

// ---- verif/bdc_panel_tb.sv ----
// self-checking bench for the panel control
// assumes shortened tick, debounce and temperature-alarm parameters
`timescale 1ns/1ps
`include "bdc_defs.svh"
module bdc_panel_tb;
   logic mclk, rst_b, cmdDoor, doorOpen, vacKeep, dispOn, applOn, vacation_message, dispSeen;
   bdc_pkg::bdc_keys_t cmdKeys, keyRaw;
   logic signed [7:0] cmdTemp, cabTemp;
   bdc_pkg::bdc_leds_t leds;
   bdc_pkg::bdc_tones_t tones;
   bdc_pkg::bdc_msg_t msg;
   logic signed [15:0] tenths;
   logic [7:0] setPt, seen;
   int miscompares = 0, n_checks = 0, nConf = 0, nLim = 0, nAlm = 0;
   bdc_panel #(.TICK_CYCLES(8), .DB_CYCLES(2), .TEMP_TICKS(50)) dut (.mclk(mclk),
      .rst_b(rst_b), .ce(1'b1), .keyRaw(keyRaw), .doorOpen(doorOpen), .cabTempF(cabTemp),
      .vacKeep(vacKeep), .leds_r(leds), .tones_r(tones), .dispMsg_r(msg), .dispOn_r(dispOn),
      .dispTenths_r(tenths), .applianceOn_r(applOn), .vacation_r(vacation_message), .setPointF_r(setPt));
   bdc_front_model front (.cmdKeys(cmdKeys), .cmdDoor(cmdDoor), .cmdTemp(cmdTemp),
      .rst_b(rst_b), .vacation_r(vacation_message), .keyRaw(keyRaw), .doorOpen(doorOpen),
      .cabTempF(cabTemp), .vacKeep(vacKeep));
   // ----------------------------------------
   // clock, tone counters, helpers
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(negedge mclk) begin
      if (tones.confirm === 1'b1) nConf++;
      if (tones.limit === 1'b1) nLim++;
      if (tones.alarm === 1'b1) nAlm++;
   end
   task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic hold(int k, int n);
      cmdKeys[k] = 1'b1;
      cyc(n);
      cmdKeys[k] = 1'b0;
      cyc(8);
   endtask
   // flashing outputs: or them over a window
   task automatic watch(int n);
      seen = 8'h00;
      dispSeen = 1'b0;
      repeat (n) begin
         @(negedge mclk);
         seen = seen | leds;
         dispSeen = dispSeen | dispOn;
      end
   endtask
   task automatic final_report;
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_powerup;
      watch(100);
      chk("pfLit", seen[5], 1'b1);
      chk("okOff", leds.ok, 1'b0);
      chk("alarmReset", leds.alarmReset, 1'b1);
      chk("pfTone", nAlm, 0);
      chk("unitF", leds.celsius, 1'b0);
      chk("setPt", setPt, 8'h26);
      hold(`BDC_K_PWR, 10);
      chk("pfClear", leds.powerFail, 1'b0);
      chk("okOn", leds.ok, 1'b1);
   endtask
   task automatic t_setpoint;
      int l;
      hold(`BDC_K_MINUS, 10);
      chk("setInd", leds.setInd, 1'b1);
      chk("msgSet", msg, bdc_pkg::MSG_SETPT);
      repeat (4) hold(`BDC_K_MINUS, 10);
      chk("edit", tenths, 16'h0154);
      l = nLim;
      hold(`BDC_K_MINUS, 10);
      chk("limTone", nLim, l + 1);
      chk("editLim", tenths, 16'h0154);
      hold(`BDC_K_PWR, 10);
      chk("accept", setPt, 8'h22);
      chk("setExit", leds.setInd, 1'b0);
      hold(`BDC_K_PLUS, 10);
      hold(`BDC_K_PLUS, 10);
      cyc(900);
      chk("timeout", setPt, 8'h23);
   endtask
   task automatic t_unit_onoff;
      cmdKeys[`BDC_K_MINUS] = 1'b1;
      cyc(10);
      hold(`BDC_K_PLUS, 10);
      cmdKeys[`BDC_K_MINUS] = 1'b0;
      cyc(900);
      chk("celsius", leds.celsius, 1'b1);
      chk("noStep", setPt, 8'h23);
      hold(`BDC_K_PWR, 400);
      chk("off", applOn, 1'b0);
      chk("msgOff", msg, bdc_pkg::MSG_OFF);
      hold(`BDC_K_PWR, 400);
      chk("on", applOn, 1'b1);
      chk("msgTemp", msg, bdc_pkg::MSG_TEMP);
   endtask
   task automatic t_lock;
      hold(`BDC_K_LOCK, 300);
      cyc(400);
      chk("lockIcon", leds.lockIcon, 1'b1);
      hold(`BDC_K_MINUS, 10);
      chk("lockedKey", leds.setInd, 1'b0);
      hold(`BDC_K_LOCK, 300);
      hold(`BDC_K_MINUS, 10);
      chk("unlocked", leds.setInd, 1'b1);
      cyc(900);
   endtask
   task automatic t_nosleep;
      cmdKeys[`BDC_K_LOCK] = 1'b1;
      cyc(500);
      chk("msgNsl", msg, bdc_pkg::MSG_NOSLEEP);
      cmdKeys[`BDC_K_LOCK] = 1'b0;
      cyc(5000);
      chk("noSleep", dispOn, 1'b1);
      cmdKeys[`BDC_K_LOCK] = 1'b1;
      cyc(500);
      chk("msgSlp", msg, bdc_pkg::MSG_SLEEPEN);
      cmdKeys[`BDC_K_LOCK] = 1'b0;
      cyc(8);
   endtask
   task automatic t_sleep;
      int c;
      cyc(5000);
      chk("dark", dispOn, 1'b0);
      chk("okOnly", leds, 8'h80);
      c = nConf;
      hold(`BDC_K_MINUS, 10);
      chk("confirm", nConf, c + 1);
      chk("woken", dispOn, 1'b1);
      chk("wakeOnly", leds.setInd, 1'b0);
   endtask
   task automatic t_alarms;
      cyc(5000);
      cmdDoor = 1'b1;
      cmdTemp = 8'h3C;
      cyc(420);
      watch(100);
      chk("tempLit", seen[4], 1'b1);
      chk("alarmWake", dispSeen, 1'b1);
      chk("okOff", leds.ok, 1'b0);
      chk("alarmReset", leds.alarmReset, 1'b1);
      chk("tempTone", nAlm != 0, 1'b1);
      cyc(23600);
      watch(100);
      chk("doorLit", seen[6], 1'b1);
      chk("bothLit", seen[4], 1'b1);
      cmdDoor = 1'b0;
      cyc(4);
      watch(100);
      chk("doorClr", seen[6], 1'b0);
      chk("tempKept", seen[4], 1'b1);
      cmdTemp = 8'h23;
      hold(`BDC_K_PWR, 10);
      chk("tempClr", leds.tempAlarm, 1'b0);
      chk("okBack", leds.ok, 1'b1);
   endtask
   task automatic t_vacation;
      int c;
      hold(`BDC_K_PWR, 700);
      chk("vacOn", vacation_message, 1'b1);
      chk("msgVac", msg, bdc_pkg::MSG_VAC);
      cyc(400);
      chk("ledsOff", leds, 8'h00);
      c = nConf;
      hold(`BDC_K_MINUS, 10);
      chk("noTone", nConf, c);
      cmdDoor = 1'b1;
      cyc(10);
      cmdDoor = 1'b0;
      cyc(10);
      chk("doorQuiet", leds, 8'h00);
      rst_b = 1'b0;
      cyc(4);
      rst_b = 1'b1;
      cyc(4);
      chk("vacKept", vacation_message, 1'b1);
      hold(`BDC_K_PWR, 400);
      chk("vacExit", vacation_message, 1'b0);
   endtask
   initial begin
      #4_000_000;
      miscompares++;
      final_report;
   end
   initial begin
      cmdKeys = '0;
      cmdDoor = 1'b0;
      cmdTemp = 8'h26;
      rst_b = 1'b0;
      cyc(4);
      rst_b = 1'b1;
      cyc(4);
      t_powerup;
      t_setpoint;
      t_unit_onoff;
      t_lock;
      t_nosleep;
      t_sleep;
      t_alarms;
      t_vacation;
      final_report;
   end
endmodule
